/* File: hw/drive_seq_ctrl.sv */
// Motor sequence control with factory-reset and save sequencer.
`timescale 1ns/10ps
`default_nettype none

module drive_seq_ctrl #(
  parameter logic [31:0] SAFETY_PASSWORD = 32'h0000_0000, // Arbitrary neutral value.
  parameter int RESET_CYCLES = drive_seq_pkg::RESET_CYCLES,
  parameter int SAVE_CYCLES = drive_seq_pkg::SAVE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic standstill,
  input wire logic power_cycle,
  output logic motor_on,
  output logic ramp_brake,
  output logic quick_brake,
  output logic current_limit_brake,
  output logic [15:0] ramp_time,
  output logic [2:0] state_code
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  // Command bits written by the controller.
  logic [drive_seq_pkg::CTL_WIDTH-1:0] control_r;
  // Sequence state and its next value.
  drive_seq_pkg::seq_state_t state_r;
  drive_seq_pkg::seq_state_t state_nxt;
  // Reset and save parameters.
  logic [7:0] commissioning_selector_r;
  logic [31:0] safety_password_r;
  logic [7:0] reset_trigger_r;
  logic [7:0] save_trigger_r;
  // Working settings.
  logic [15:0] ramp_time_r;
  logic [15:0] quick_time_r;
  logic [15:0] comm_setting_r;
  logic [15:0] motor_std_r;
  logic [15:0] safety_work_r;
  // Safety settings currently in force.
  logic [15:0] safety_applied_r;
  // Non-volatile image written by the save sequence.
  logic [15:0] nv_ramp_r;
  logic [15:0] nv_quick_r;
  logic [15:0] nv_safety_r;
  // Sequencer busy counters.
  logic [15:0] reset_cnt_r;
  logic [15:0] save_cnt_r;
  logic reset_busy_r;
  logic reset_safety_r;
  logic save_busy_r;
  // Sticky flag set when a safety reset was refused.
  logic refused_r;
  // Decoded commands.
  logic switch_on;
  logic coast_stop;
  logic quick_stop;
  logic op_enable;
  logic auto_start;
  // Decoded writes and sequencer events.
  logic wr_reset_trig;
  logic safety_ok;
  logic safety_start;
  logic std_start;
  logic std_done;
  logic safety_done;
  logic save_start;
  logic save_done;
  logic drive_reset_go;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign switch_on = control_r[drive_seq_pkg::CTL_SWITCH_ON];
  assign coast_stop = control_r[drive_seq_pkg::CTL_COAST_STOP];
  assign quick_stop = control_r[drive_seq_pkg::CTL_QUICK_STOP];
  assign op_enable = control_r[drive_seq_pkg::CTL_OP_ENABLE];
  assign auto_start = control_r[drive_seq_pkg::CTL_AUTO_START];

  // Password and selector must both be in place before a safety reset.
  assign safety_ok = (commissioning_selector_r == drive_seq_pkg::SELECTOR_RESET_MODE) &&
                     (safety_password_r == SAFETY_PASSWORD);
  assign wr_reset_trig = wr_en && (addr == drive_seq_pkg::RESET_TRIG_ADDR) &&
                         !reset_busy_r;
  assign safety_start = wr_reset_trig &&
                        (wr_data[7:0] == drive_seq_pkg::TRIG_SAFETY_RESET) && safety_ok;
  // The panel entry and trigger value 1 share the non-safety path.
  assign drive_reset_go = wr_en && (addr == drive_seq_pkg::DRIVE_RESET_ADDR) &&
                          (wr_data[7:0] == drive_seq_pkg::DRIVE_RESET_CONFIRM);
  assign std_start = !reset_busy_r &&
                     ((wr_reset_trig && (wr_data[7:0] == drive_seq_pkg::TRIG_STD_RESET)) ||
                      drive_reset_go);
  assign std_done = reset_busy_r && !reset_safety_r &&
                    (reset_cnt_r == 16'(RESET_CYCLES - 1));
  assign safety_done = reset_busy_r && reset_safety_r &&
                       (reset_cnt_r == 16'(RESET_CYCLES - 1));
  assign save_start = wr_en && (addr == drive_seq_pkg::SAVE_TRIG_ADDR) && !save_busy_r &&
                      (wr_data[7:0] == drive_seq_pkg::SAVE_START);
  assign save_done = save_busy_r && (save_cnt_r == 16'(SAVE_CYCLES - 1));

  // ------------------------------------------------------------
  // Sequence state machine
  // ------------------------------------------------------------
  // Next-state logic; stop commands are checked in priority order.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      drive_seq_pkg::power_up_state: begin
        // An active switch-on at power-up blocks start unless automatic start.
        if (coast_stop || quick_stop) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else if (switch_on && !auto_start) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else begin
          state_nxt = drive_seq_pkg::ready_to_switch_on_state;
        end
      end
      drive_seq_pkg::switch_on_inhibited_state: begin
        // Switch-on is ignored; leave only once it and every stop are gone.
        if (!coast_stop && !quick_stop && !switch_on) begin
          state_nxt = drive_seq_pkg::ready_to_switch_on_state;
        end
      end
      drive_seq_pkg::ready_to_switch_on_state: begin
        if (coast_stop || quick_stop) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else if (switch_on) begin
          state_nxt = drive_seq_pkg::ready_state;
        end
      end
      drive_seq_pkg::ready_state: begin
        if (coast_stop || quick_stop) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else if (!switch_on) begin
          state_nxt = drive_seq_pkg::ready_to_switch_on_state;
        end else if (op_enable) begin
          state_nxt = drive_seq_pkg::operation_state;
        end
      end
      drive_seq_pkg::operation_state: begin
        // Coast first, then quick stop, then normal stop.
        if (coast_stop) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else if (quick_stop) begin
          state_nxt = drive_seq_pkg::quick_braking_state;
        end else if (!switch_on) begin
          state_nxt = drive_seq_pkg::ramp_braking_state;
        end else if (!op_enable) begin
          state_nxt = drive_seq_pkg::ready_state;
        end
      end
      drive_seq_pkg::ramp_braking_state: begin
        if (coast_stop) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end else if (quick_stop) begin
          state_nxt = drive_seq_pkg::quick_braking_state;
        end else if (standstill) begin
          state_nxt = drive_seq_pkg::ready_to_switch_on_state;
        end
      end
      drive_seq_pkg::quick_braking_state: begin
        if (coast_stop || standstill) begin
          state_nxt = drive_seq_pkg::switch_on_inhibited_state;
        end
      end
      default: begin
        state_nxt = drive_seq_pkg::power_up_state;
      end
    endcase
  end

  // State register; a supply restore re-runs the power-up decision.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= drive_seq_pkg::power_up_state;
    end else if (clk_en) begin
      if (power_cycle) begin
        state_r <= drive_seq_pkg::power_up_state;
      end else begin
        state_r <= state_nxt;
      end
    end
  end

  // ------------------------------------------------------------
  // Drive outputs
  // ------------------------------------------------------------
  // Motor energy, brake selection and the ramp time handed to the ramp generator.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      motor_on <= 1'b0;
      ramp_brake <= 1'b0;
      quick_brake <= 1'b0;
      current_limit_brake <= 1'b0;
      ramp_time <= drive_seq_pkg::RAMP_TIME_DEFAULT;
      state_code <= 3'h0;
    end else if (clk_en) begin
      // Energized in operation and while braking under control.
      motor_on <= (state_nxt == drive_seq_pkg::operation_state) ||
                  (state_nxt == drive_seq_pkg::ramp_braking_state) ||
                  (state_nxt == drive_seq_pkg::quick_braking_state);
      ramp_brake <= (state_nxt == drive_seq_pkg::ramp_braking_state);
      quick_brake <= (state_nxt == drive_seq_pkg::quick_braking_state);
      current_limit_brake <= (state_nxt == drive_seq_pkg::quick_braking_state) &&
                             control_r[drive_seq_pkg::CTL_CURR_LIMIT];
      // Quick braking takes its own ramp time, all else the normal one.
      if (state_nxt == drive_seq_pkg::quick_braking_state) begin
        ramp_time <= quick_time_r;
      end else begin
        ramp_time <= ramp_time_r;
      end
      state_code <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Controller-written parameters
  // ------------------------------------------------------------
  // Command bits, selector and password.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_r <= '0;
      commissioning_selector_r <= 8'h00;
      safety_password_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_en && (addr == drive_seq_pkg::CONTROL_ADDR)) begin
        control_r <= wr_data[drive_seq_pkg::CTL_WIDTH-1:0];
      end
      if (wr_en && (addr == drive_seq_pkg::SELECTOR_ADDR)) begin
        commissioning_selector_r <= wr_data[7:0];
      end
      if (wr_en && (addr == drive_seq_pkg::PASSWORD_ADDR)) begin
        safety_password_r <= wr_data;
      end
    end
  end

  // Working settings; a finished reset restores defaults on its own path.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ramp_time_r <= drive_seq_pkg::RAMP_TIME_DEFAULT;
      quick_time_r <= drive_seq_pkg::QUICK_TIME_DEFAULT;
      comm_setting_r <= 16'h0000;
      motor_std_r <= 16'h0000;
      safety_work_r <= drive_seq_pkg::SAFETY_DEFAULT;
    end else if (clk_en) begin
      if (power_cycle) begin
        // Supply restore reloads from the non-volatile image.
        ramp_time_r <= nv_ramp_r;
        quick_time_r <= nv_quick_r;
        safety_work_r <= nv_safety_r;
      end else if (std_done) begin
        // Communication and motor standard are left alone.
        ramp_time_r <= drive_seq_pkg::RAMP_TIME_DEFAULT;
        quick_time_r <= drive_seq_pkg::QUICK_TIME_DEFAULT;
      end else if (safety_done) begin
        safety_work_r <= drive_seq_pkg::SAFETY_DEFAULT;
      end else if (wr_en) begin
        if (addr == drive_seq_pkg::RAMP_TIME_ADDR) begin
          ramp_time_r <= wr_data[15:0];
        end
        if (addr == drive_seq_pkg::QUICK_TIME_ADDR) begin
          quick_time_r <= wr_data[15:0];
        end
        if (addr == drive_seq_pkg::COMM_ADDR) begin
          comm_setting_r <= wr_data[15:0];
        end
        if (addr == drive_seq_pkg::MOTOR_STD_ADDR) begin
          motor_std_r <= wr_data[15:0];
        end
        if (addr == drive_seq_pkg::SAFETY_WORK_ADDR) begin
          safety_work_r <= wr_data[15:0];
        end
      end
    end
  end

  // Safety settings in force change only at a supply restore.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      safety_applied_r <= drive_seq_pkg::SAFETY_DEFAULT;
    end else if (clk_en && power_cycle) begin
      safety_applied_r <= nv_safety_r;
    end
  end

  // ------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------
  // Runs a timed reset and writes the trigger back to idle when done.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_busy_r <= 1'b0;
      reset_safety_r <= 1'b0;
      reset_cnt_r <= 16'h0000;
      reset_trigger_r <= drive_seq_pkg::TRIG_IDLE;
    end else if (clk_en) begin
      if (reset_busy_r) begin
        reset_cnt_r <= reset_cnt_r + 16'h0001;
        if (std_done || safety_done) begin
          reset_busy_r <= 1'b0;
          reset_trigger_r <= drive_seq_pkg::TRIG_IDLE;
        end
      end else if (safety_start) begin
        reset_busy_r <= 1'b1;
        reset_safety_r <= 1'b1;
        reset_cnt_r <= 16'h0000;
        reset_trigger_r <= wr_data[7:0];
      end else if (std_start) begin
        reset_busy_r <= 1'b1;
        reset_safety_r <= 1'b0;
        reset_cnt_r <= 16'h0000;
        reset_trigger_r <= drive_seq_pkg::TRIG_STD_RESET;
      end else if (wr_reset_trig) begin
        // Refused or unknown request: trigger falls back to idle at once.
        reset_trigger_r <= drive_seq_pkg::TRIG_IDLE;
      end
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refused_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_reset_trig && (wr_data[7:0] == drive_seq_pkg::TRIG_SAFETY_RESET) && !safety_ok) begin
        refused_r <= 1'b1;
      end else if (wr_en && (addr == drive_seq_pkg::STATUS_ADDR) &&
                   wr_data[drive_seq_pkg::STS_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Save sequencer
  // ------------------------------------------------------------
  // Copies ramp, quick and safety settings to the non-volatile image, then clears the trigger.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      save_busy_r <= 1'b0;
      save_cnt_r <= 16'h0000;
      save_trigger_r <= drive_seq_pkg::TRIG_IDLE;
      nv_ramp_r <= drive_seq_pkg::RAMP_TIME_DEFAULT;
      nv_quick_r <= drive_seq_pkg::QUICK_TIME_DEFAULT;
      nv_safety_r <= drive_seq_pkg::SAFETY_DEFAULT;
    end else if (clk_en) begin
      if (save_busy_r) begin
        save_cnt_r <= save_cnt_r + 16'h0001;
        if (save_done) begin
          nv_ramp_r <= ramp_time_r;
          nv_quick_r <= quick_time_r;
          nv_safety_r <= safety_work_r;
          save_busy_r <= 1'b0;
          save_trigger_r <= drive_seq_pkg::TRIG_IDLE;
        end
      end else if (save_start) begin
        save_busy_r <= 1'b1;
        save_cnt_r <= 16'h0000;
        save_trigger_r <= drive_seq_pkg::SAVE_START;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  // Read data stand in the cycle after the strobe; otherwise zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (clk_en) begin
      rd_data <= 32'h0000_0000;
      if (rd_en) begin
        unique case (addr)
          drive_seq_pkg::CONTROL_ADDR: rd_data <= 32'(control_r);
          drive_seq_pkg::STATUS_ADDR: begin
            rd_data <= 32'({save_busy_r | reset_busy_r, refused_r, standstill,
                            motor_on, state_r});
          end
          drive_seq_pkg::SELECTOR_ADDR: rd_data <= 32'(commissioning_selector_r);
          drive_seq_pkg::RESET_TRIG_ADDR: rd_data <= 32'(reset_trigger_r);
          drive_seq_pkg::SAVE_TRIG_ADDR: rd_data <= 32'(save_trigger_r);
          drive_seq_pkg::RAMP_TIME_ADDR: rd_data <= 32'(ramp_time_r);
          drive_seq_pkg::QUICK_TIME_ADDR: rd_data <= 32'(quick_time_r);
          drive_seq_pkg::COMM_ADDR: rd_data <= 32'(comm_setting_r);
          drive_seq_pkg::MOTOR_STD_ADDR: rd_data <= 32'(motor_std_r);
          drive_seq_pkg::SAFETY_WORK_ADDR: rd_data <= 32'(safety_work_r);
          drive_seq_pkg::SAFETY_APPLIED_ADDR: rd_data <= 32'(safety_applied_r);
          // Password, drive-reset entry and unmapped offsets read as zero.
          default: rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : drive_seq_ctrl

`default_nettype wire

/* File: pkg/drive_seq_pkg.sv */
// Constants, state codes and register map shared by the drive sequence controller.
//
// Summary of operation
// - Power-up normally enters ready-to-switch-on and waits.
// - Switch-on command energizes motor, enters operation.
// - Normal stop ramps down, off at standstill.
// - Coast stop de-energizes motor at once.
// - Quick stop brakes with quick ramp time.
// - Operation enable low switches motor off; high on.
// - Switch-on inhibited state ignores switch-on command.
// - Switch-on at power-up inhibits unless automatic start.
// - Coast or quick stop enters switch-on inhibited.
// - Ready-to-switch-on is passed before energizing motor.
// - Ready state waits for operation enable.
// - Operation state keeps motor energized.
// - Normal braking uses ramp-function generator ramp time.
// - Quick braking uses quick ramp or current limit.
// - Safety settings reset on a separate path.
// - Safety reset refused without correct safety password.
// - Factory reset keeps communication and motor standard.
// - Trigger 5 starts safety reset; device writes 0.
// - Save trigger 1 stores settings; device clears it.
// - Drive-reset entry confirmed restores non-safety factory values.
package drive_seq_pkg;

  // ------------------------------------------------------------
  // Sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    power_up_state = 3'h0,
    switch_on_inhibited_state = 3'h1,
    ready_to_switch_on_state = 3'h2,
    ready_state = 3'h3,
    operation_state = 3'h4,
    ramp_braking_state = 3'h5,
    quick_braking_state = 3'h6
  } seq_state_t;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] SELECTOR_ADDR = 8'h08;
  localparam logic [7:0] PASSWORD_ADDR = 8'h0C;
  localparam logic [7:0] RESET_TRIG_ADDR = 8'h10;
  localparam logic [7:0] SAVE_TRIG_ADDR = 8'h14;
  localparam logic [7:0] DRIVE_RESET_ADDR = 8'h18;
  localparam logic [7:0] RAMP_TIME_ADDR = 8'h1C;
  localparam logic [7:0] QUICK_TIME_ADDR = 8'h20;
  localparam logic [7:0] COMM_ADDR = 8'h24;
  localparam logic [7:0] MOTOR_STD_ADDR = 8'h28;
  localparam logic [7:0] SAFETY_WORK_ADDR = 8'h2C;
  localparam logic [7:0] SAFETY_APPLIED_ADDR = 8'h30;

  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int CTL_SWITCH_ON = 0;
  localparam int CTL_COAST_STOP = 1;
  localparam int CTL_QUICK_STOP = 2;
  localparam int CTL_OP_ENABLE = 3;
  localparam int CTL_AUTO_START = 4;
  localparam int CTL_CURR_LIMIT = 5;
  localparam int CTL_WIDTH = 6;

  // ------------------------------------------------------------
  // Status register bit positions
  // ------------------------------------------------------------
  localparam int STS_STATE_LSB = 0;
  localparam int STS_MOTOR_ON = 3;
  localparam int STS_STANDSTILL = 4;
  localparam int STS_REFUSED = 5;
  localparam int STS_BUSY = 6;

  // ------------------------------------------------------------
  // Parameter values and factory defaults
  // ------------------------------------------------------------
  localparam logic [7:0] SELECTOR_RESET_MODE = 8'h1E;
  localparam logic [7:0] TRIG_SAFETY_RESET = 8'h05;
  localparam logic [7:0] TRIG_STD_RESET = 8'h01;
  localparam logic [7:0] SAVE_START = 8'h01;
  localparam logic [7:0] TRIG_IDLE = 8'h00;
  localparam logic [7:0] DRIVE_RESET_CONFIRM = 8'h01;
  localparam logic [15:0] RAMP_TIME_DEFAULT = 16'h000A;
  localparam logic [15:0] QUICK_TIME_DEFAULT = 16'h0000;
  localparam logic [15:0] SAFETY_DEFAULT = 16'h0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int RESET_TIME_US = 10;
  localparam int SAVE_TIME_US = 20;
  localparam int RESET_CYCLES = RESET_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SAVE_CYCLES = SAVE_TIME_US * (CLK_HZ / 1_000_000);

endpackage : drive_seq_pkg

/* File: tb/drive_seq_checker.sv */
// Port checker for the drive sequence controller.
`timescale 1ns/10ps
`default_nettype none
module drive_seq_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic standstill,
  input wire logic power_cycle,
  input wire logic motor_on,
  input wire logic ramp_brake,
  input wire logic quick_brake,
  input wire logic current_limit_brake,
  input wire logic [15:0] ramp_time,
  input wire logic [2:0] state_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A control word taken from the bus.
  sequence ctl_wr_s;
    wr_en && clk_en && !power_cycle && addr == drive_seq_pkg::CONTROL_ADDR;
  endsequence
  // Braking has ended and nothing new was requested.
  sequence stop_s(logic [2:0] s);
    state_code == s && standstill && clk_en && !wr_en && !power_cycle;
  endsequence
  coast_off_a: assert property (ctl_wr_s ##0 wr_data[1] ##1 (clk_en && !power_cycle)
    |=> state_code == 3'h1 && !motor_on)
    else $error("coast stop did not inhibit");
  quick_go_a: assert property (ctl_wr_s ##0 wr_data[2:1] == 2'b10 && state_code == 3'h4
    ##1 (clk_en && !power_cycle) |=> state_code == 3'h6)
    else $error("quick stop did not brake");
  stop_wait_a: assert property (stop_s(3'h5) |=> state_code == 3'h2)
    else $error("ramp stop did not end ready");
  quick_end_a: assert property (stop_s(3'h6) |=> state_code == 3'h1)
    else $error("quick stop did not inhibit");
  enable_off_a: assert property (ctl_wr_s ##0 wr_data[3:0] == 4'h1 && state_code == 3'h4
    ##1 (clk_en && !power_cycle) |=> state_code == 3'h3 && !motor_on)
    else $error("enable removal kept motor on");
  opr_on_a: assert property (state_code == 3'h4 |-> motor_on)
    else $error("operation without motor");
  ramp_sel_a: assert property (state_code == 3'h5 |-> ramp_brake && !quick_brake)
    else $error("wrong brake in ramp stop");
  inhib_hold_a: assert property (state_code == 3'h1 |=> state_code inside {3'h0, 3'h1, 3'h2})
    else $error("inhibited state left wrongly");
  via_ready_a: assert property ($rose(motor_on) |-> $past(state_code) == 3'h3)
    else $error("motor on without ready");
  status_rd_a: assert property (rd_en && clk_en && addr == drive_seq_pkg::STATUS_ADDR
    |=> rd_data[2:0] == $past(state_code))
    else $error("status read wrong state");
endmodule : drive_seq_checker
bind drive_seq_ctrl drive_seq_checker chk_u (.ref_clk, .rst, .clk_en, .addr, .wr_data, .wr_en,
  .rd_en, .rd_data, .standstill, .power_cycle, .motor_on, .ramp_brake, .quick_brake,
  .current_limit_brake, .ramp_time, .state_code);
`default_nettype wire

/* File: tb/motor_model.sv */
// Motor model that reports standstill a while after torque stops driving it.
`timescale 1ns/10ps
`default_nettype none
module motor_model #(parameter int STOP_CYCLES = 8) (
  input wire logic ref_clk,
  input wire logic motor_on,
  input wire logic ramp_brake,
  input wire logic quick_brake,
  output logic standstill
);
  int cnt_r = 0; // Cycles spent slowing down.
  // The shaft needs STOP_CYCLES to stop, so braking is never instant.
  always_ff @(posedge ref_clk) begin
    if (motor_on && !ramp_brake && !quick_brake)
      cnt_r <= 0;
    else if (cnt_r < STOP_CYCLES)
      cnt_r <= cnt_r + 1;
  end
  assign standstill = (cnt_r == STOP_CYCLES);
endmodule : motor_model
`default_nettype wire

/* File: tb/drive_seq_ctrl_test.sv */
// Self-checking bench for the drive sequence controller.
`timescale 1ns/10ps
`default_nettype none
module drive_seq_ctrl_test;
  localparam logic [31:0] PW = 32'h3C5A_0F96; // Arbitrary password value.
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic power_cycle = 1'b0, standstill, motor_on, ramp_brake, quick_brake, cl_brake;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, v, r1, r2;
  logic [31:0] seed = 32'h0001_0F39; // Starting value 69433.
  logic [15:0] ramp_time;
  logic [2:0] state_code;
  int err_total = 0, num_checks = 0;
  // Control words and the state each must lead to.
  logic [3:0] ctl_q [12] = '{4'h9, 4'h1, 4'h9, 4'h8, 4'h8, 4'h9, 4'hF, 4'h9, 4'h0, 4'h9, 4'hD, 4'hD};
  logic [2:0] st_q [12] = '{3'h4, 3'h3, 3'h4, 3'h5, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h4, 3'h6, 3'h1};
  drive_seq_ctrl #(.SAFETY_PASSWORD(PW), .RESET_CYCLES(2), .SAVE_CYCLES(2)) dut_u (.ref_clk,
    .rst, .clk_en, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .standstill, .power_cycle,
    .motor_on, .ramp_brake, .quick_brake, .current_limit_brake(cl_brake), .ramp_time, .state_code);
  motor_model #(.STOP_CYCLES(8)) motor_u (.ref_clk, .motor_on, .ramp_brake, .quick_brake,
    .standstill);
  initial forever #50 ref_clk = ~ref_clk;
  // Next value of the xorshift generator.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected status low nibble: state code with the motor bit set in operation.
  function automatic logic [31:0] st_word(input logic [2:0] s);
    return {28'h0, s == 3'h4, s};
  endfunction : st_word
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    #(100 * 3000);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(drive_seq_pkg::STATUS_ADDR);
    chk("state", v & 32'h7, 32'h2);
    for (int i = 0; i < 12; i++) begin
      // Step 10 also asks for braking at the current limit.
      wr(drive_seq_pkg::CONTROL_ADDR, {26'h0, i == 10, 1'b0, ctl_q[i]});
      // Braking steps 4 and 11 wait 12 cycles for the 8-cycle run-down to standstill; all other steps wait one cycle.
      repeat ((i == 4 || i == 11) ? 12 : 1) @(posedge ref_clk);
      rd(drive_seq_pkg::STATUS_ADDR);
      chk("state", v & ((st_q[i] < 3'h5) ? 32'hF : 32'h7), st_word(st_q[i]));
      if (i == 10) begin
        chk("limit", {31'h0, cl_brake}, 32'h1);
        chk("quick", {31'h0, quick_brake}, 32'h1);
        chk("quick_time", {16'h0, ramp_time}, 32'h0);
      end
    end
    wr(drive_seq_pkg::CONTROL_ADDR, 32'h0);
    r1 = rnd() & 32'hFFFF;
    wr(drive_seq_pkg::SAFETY_WORK_ADDR, r1);
    wr(drive_seq_pkg::SAVE_TRIG_ADDR, 32'h1);
    repeat (6) @(posedge ref_clk);
    rd(drive_seq_pkg::SAVE_TRIG_ADDR);
    chk("save", v, 32'h0);
    @(posedge ref_clk) power_cycle <= 1'b1;
    @(posedge ref_clk) power_cycle <= 1'b0;
    rd(drive_seq_pkg::SAFETY_APPLIED_ADDR);
    chk("applied", v, r1);
    wr(drive_seq_pkg::SELECTOR_ADDR, 32'h1E);
    wr(drive_seq_pkg::PASSWORD_ADDR, PW ^ rnd() | 32'h1);
    wr(drive_seq_pkg::RESET_TRIG_ADDR, 32'h5);
    repeat (6) @(posedge ref_clk);
    rd(drive_seq_pkg::STATUS_ADDR);
    chk("refused", v & 32'h20, 32'h20);
    wr(drive_seq_pkg::PASSWORD_ADDR, PW);
    wr(drive_seq_pkg::RESET_TRIG_ADDR, 32'h5);
    repeat (6) @(posedge ref_clk);
    rd(drive_seq_pkg::RESET_TRIG_ADDR);
    chk("trigger", v, 32'h0);
    rd(drive_seq_pkg::SAFETY_WORK_ADDR);
    chk("safety", v, 32'h0);
    rd(drive_seq_pkg::SAFETY_APPLIED_ADDR);
    chk("applied", v, r1);
    r2 = rnd() & 32'hFF;
    wr(drive_seq_pkg::COMM_ADDR, r2);
    wr(drive_seq_pkg::RAMP_TIME_ADDR, rnd() & 32'hFFFF);
    wr(drive_seq_pkg::DRIVE_RESET_ADDR, 32'h1);
    repeat (6) @(posedge ref_clk);
    rd(drive_seq_pkg::COMM_ADDR);
    chk("comm", v, r2);
    rd(drive_seq_pkg::RAMP_TIME_ADDR);
    chk("ramp", v, 32'hA);
    chk("ramp_time", {16'h0, ramp_time}, 32'hA);
    give_verdict();
  end
endmodule : drive_seq_ctrl_test
`default_nettype wire
